// [design/tldc_top.sv]
// transmit line driver control: high-z decision, over-current, template rom, apb registers
//
// The APB register port and the register addresses were decided locally.
`include "tldc_defines.svh"
module tldc_top #(
  parameter int MCLK_LOSS_CYC = `TLDC_MCLK_LOSS_CYC,
  parameter int SETTLE_CYC    = `TLDC_SETTLE_CYC
) (
  input  wire logic                   pclk,                  // master clock, 100 MHz
  input  wire logic                   presetn,               // power-on reset, async, low
  input  wire logic [11:0]            paddr,                 // apb byte address
  input  wire logic                   psel,                  // apb select
  input  wire logic                   penable,               // apb access phase
  input  wire logic                   pwrite,                // apb direction
  input  wire logic [31:0]            pwdata,                // apb write data
  output logic      [31:0]            prdata,                // apb read data
  output logic                        pready,                // apb ready
  output logic                        pslverr,               // apb error, unmapped
  input  wire logic                   oe_pin,                // global output enable pin
  input  wire logic                   mclk_pin,              // master clock reference pin
  input  wire logic                   rst_pin_n,             // hardware reset pin
  input  wire logic [`TLDC_NCH-1:0]   tx_sys_clock,          // system transmit clocks
  input  wire logic [`TLDC_NCH-1:0]   tx_sys_data,           // system transmit data
  input  wire logic [`TLDC_NCH-1:0]   tx_overcurrent,        // driver over-current detect
  input  wire logic [`TLDC_NCH-1:0]   tx_nrz_format,         // channel in an nrz format
  input  wire logic [`TLDC_NCH-1:0]   tx_loop_or_pattern,    // remote loop or line_rate_clock pattern
  output logic      [`TLDC_NCH-1:0]   line_out_tip_oe,       // tip driver enable
  output logic      [`TLDC_NCH-1:0]   line_out_ring_oe,      // ring driver enable
  output logic      [`TLDC_NCH-1:0]   current_limit,         // limit current to 100 mA pp
  output logic      [`TLDC_NCH*3-1:0] tx_termination,        // termination code per channel
  output logic      [`TLDC_NCH-1:0]   tx_multifunction_out,  // over-current indication
  output logic      [`TLDC_NCH-1:0]   tx_multifunction_oe,   // multifunction driver enable
  output logic      [`TLDC_NCH-1:0]   tx_core_data,          // gated system data to core
  output logic                        line_rate_clock,       // line-rate tick, one cycle
  output logic                        irq_n                  // interrupt, active low
);
  // ----------------------------------------------------------------------
  // template rom: eight templates of twenty samples
  // ----------------------------------------------------------------------
  localparam tldc_pkg::tldc_sample_t ROM [`TLDC_ROM_DEPTH] = '{
    7'h00, 7'h00, 7'h00, 7'h0c, 7'h30, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
    7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
    7'h00, 7'h00, 7'h00, 7'h0f, 7'h3c, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
    7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
    7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23, 7'h4a,
    7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00, 7'h00,
    7'h1b, 7'h2e, 7'h2c, 7'h2a, 7'h29, 7'h28, 7'h27, 7'h26, 7'h25, 7'h50,
    7'h4f, 7'h4d, 7'h4a, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00,
    7'h1f, 7'h34, 7'h2f, 7'h2c, 7'h2b, 7'h2a, 7'h29, 7'h28, 7'h25, 7'h57,
    7'h53, 7'h50, 7'h4b, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00,
    7'h20, 7'h3b, 7'h35, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h2a, 7'h28, 7'h58,
    7'h58, 7'h53, 7'h4c, 7'h48, 7'h46, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00,
    7'h20, 7'h3f, 7'h38, 7'h33, 7'h2f, 7'h2e, 7'h2d, 7'h2c, 7'h29, 7'h5f,
    7'h5e, 7'h57, 7'h4f, 7'h49, 7'h47, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00,
    7'h17, 7'h27, 7'h27, 7'h26, 7'h25, 7'h25, 7'h25, 7'h24, 7'h23, 7'h4a,
    7'h4a, 7'h49, 7'h47, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h00, 7'h00
  };

  localparam int SW = 3 + 3 * `TLDC_NCH;
  localparam logic [`TLDC_ACC_W-1:0] INC_T1 = `TLDC_ACC_W'(`TLDC_INC(`TLDC_T1_KHZ));
  localparam logic [`TLDC_ACC_W-1:0] INC_E1 = `TLDC_ACC_W'(`TLDC_INC(`TLDC_E1_KHZ));

  // ----------------------------------------------------------------------
  // pin synchronisers: two flops, then a third stage for edge detection
  // ----------------------------------------------------------------------
  logic [SW-1:0] sync1_q, sync2_q, sync3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {oe_pin, mclk_pin, rst_pin_n, tx_sys_clock, tx_sys_data, tx_overcurrent};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  wire                 oe_s    = sync2_q[SW-1];
  wire                 mclk_ed = sync2_q[SW-2] ^ sync3_q[SW-2];
  wire                 rstp_s  = sync2_q[SW-3];
  wire [`TLDC_NCH-1:0] tclk_s  = sync2_q[3*`TLDC_NCH-1:2*`TLDC_NCH];
  wire [`TLDC_NCH-1:0] tclk_p  = sync3_q[3*`TLDC_NCH-1:2*`TLDC_NCH];
  wire [`TLDC_NCH-1:0] tdat_s  = sync2_q[2*`TLDC_NCH-1:`TLDC_NCH];
  wire [`TLDC_NCH-1:0] oc_s    = sync2_q[`TLDC_NCH-1:0];

  // ----------------------------------------------------------------------
  // apb decode: zero wait states, unmapped addresses answer pslverr
  // ----------------------------------------------------------------------
  wire             acc     = psel & penable;
  wire             glob    = paddr[`TLDC_GLOBAL_BIT];
  wire [3:0]       reg_idx = paddr[5:2];
  wire [3:0]       ch_sel  = paddr[9:6];
  wire             wr_acc  = acc & pwrite;
  wire             ch_map  = !glob && !paddr[11] && (reg_idx <= `TLDC_OFF_CHCFG);
  wire             gl_map  = glob && !paddr[11] && (paddr[9:6] == 4'h0) && (reg_idx <= `TLDC_OFF_ROMDAT);
  wire             mapped  = ch_map | gl_map;
  wire             wr_ch   = wr_acc & ch_map;
  wire             swrst   = wr_acc & gl_map & (reg_idx == `TLDC_OFF_SWRST);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

  // ----------------------------------------------------------------------
  // global state: mode, rom pointer, reset pin filter, master clock watch
  // ----------------------------------------------------------------------
  logic        e1_mode_q;
  logic [3:0]  tpl_sel_q;
  logic [4:0]  samp_idx_q;
  logic [7:0]  hwrst_cnt_q;
  logic [16:0] mclk_idle_q;
  logic [`TLDC_ACC_W:0] acc_q;
  wire   hw_rst    = (hwrst_cnt_q >= 8'(`TLDC_HWRST_CYC));
  wire   glob_rst  = hw_rst | swrst;
  wire   mclk_loss = (mclk_idle_q >= 17'(MCLK_LOSS_CYC));
  wire   gl_wr     = wr_acc & gl_map;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e1_mode_q  <= 1'b0;
      tpl_sel_q  <= 4'h0;
      samp_idx_q <= 5'h00;
    end else if (glob_rst) begin
      e1_mode_q  <= 1'b0;
      tpl_sel_q  <= 4'h0;
      samp_idx_q <= 5'h00;
    end else if (gl_wr && reg_idx == `TLDC_OFF_GCFG) begin
      e1_mode_q  <= pwdata[`TLDC_B_E1];
    end else if (gl_wr && reg_idx == `TLDC_OFF_ROMSEL) begin
      tpl_sel_q  <= pwdata[3:0];
      samp_idx_q <= pwdata[`TLDC_ROMSEL_SAMP +: 5];
    end
  end

  // counts cycles that the reset pin is low; short glitches are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hwrst_cnt_q <= 8'h00;
    end else if (rstp_s) begin
      hwrst_cnt_q <= 8'h00;
    end else if (!hw_rst) begin
      hwrst_cnt_q <= hwrst_cnt_q + 8'h01;
    end
  end

  // idle time of the master clock reference, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_idle_q <= 17'h00000;
    end else if (mclk_ed) begin
      mclk_idle_q <= 17'h00000;
    end else if (!mclk_loss) begin
      mclk_idle_q <= mclk_idle_q + 17'h00001;
    end
  end

  // phase accumulator: carry out is the line-rate tick, jitter of one pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
    end else begin
      acc_q <= {1'b0, acc_q[`TLDC_ACC_W-1:0]} + {1'b0, (e1_mode_q ? INC_E1 : INC_T1)};
    end
  end
  wire xtick = acc_q[`TLDC_ACC_W];
  assign line_rate_clock = xtick;

  // rom read: template index times twenty plus sample, sample 1 first
  wire [7:0] rom_addr = ({5'h00, tpl_sel_q[2:0]} * 8'd20) + {3'h0, samp_idx_q - 5'd1};
  wire       rom_ok   = !tpl_sel_q[3] && (samp_idx_q != 5'h00) && (samp_idx_q <= 5'(`TLDC_NSAMP));
  wire tldc_pkg::tldc_sample_t rom_val = rom_ok ? ROM[rom_addr] : 7'h00;

  // ----------------------------------------------------------------------
  // per-channel logic
  // ----------------------------------------------------------------------
  logic [6:0]  txcfg_q  [`TLDC_NCH];
  logic        channel_soft_reset_q  [`TLDC_NCH];
  logic        oc_ist_q [`TLDC_NCH];
  logic        oc_es_q  [`TLDC_NCH];
  logic        oc_msk_q [`TLDC_NCH];
  logic        tcklos   [`TLDC_NCH];
  logic        settle   [`TLDC_NCH];
  logic [`TLDC_NCH-1:0] irq_vec;

  genvar c;
  generate
    for (c = 0; c < `TLDC_NCH; c++) begin : g_ch
      logic        oc_live_q, toff_prev_q, mf_q, dat_q;
      logic [6:0]  tck_idle_q;
      logic [16:0] settle_q;
      wire   sel    = wr_ch && (ch_sel == 4'(c));
      wire   off    = txcfg_q[c][`TLDC_B_TOFF];
      wire   oc_rise = oc_s[c] & ~oc_live_q;
      wire   oc_any  = oc_s[c] ^ oc_live_q;
      wire   oc_set  = oc_es_q[c] ? oc_any : oc_rise;
      wire   oc_clr  = sel && reg_idx == `TLDC_OFF_IRQST0 && pwdata[`TLDC_B_OC];
      wire   tck_ed  = (tclk_s[c] ^ tclk_p[c]) & ~off;

      // configuration registers
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          txcfg_q[c]  <= `TLDC_RST_TXCFG0;
          channel_soft_reset_q[c]  <= 1'b0;
          oc_es_q[c]  <= 1'b0;
          oc_msk_q[c] <= `TLDC_RST_IRQMSK;
        end else if (glob_rst) begin
          txcfg_q[c]  <= `TLDC_RST_TXCFG0;
          channel_soft_reset_q[c]  <= 1'b0;
          oc_es_q[c]  <= 1'b0;
          oc_msk_q[c] <= `TLDC_RST_IRQMSK;
        end else if (sel) begin
          if (reg_idx == `TLDC_OFF_TXCFG0)  txcfg_q[c]  <= pwdata[6:0];
          if (reg_idx == `TLDC_OFF_CHCFG)   channel_soft_reset_q[c]  <= pwdata[`TLDC_B_CHANNEL_SOFT_RESET];
          if (reg_idx == `TLDC_OFF_IRQES)   oc_es_q[c]  <= pwdata[`TLDC_B_OC];
          if (reg_idx == `TLDC_OFF_IRQMSK0) oc_msk_q[c] <= pwdata[`TLDC_B_OC];
        end
      end

      // live and sticky over-current status; a new event beats the clear
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          oc_live_q   <= 1'b0;
          oc_ist_q[c] <= 1'b0;
        end else begin
          oc_live_q   <= oc_s[c];
          oc_ist_q[c] <= glob_rst ? 1'b0 : (oc_set | (oc_ist_q[c] & ~oc_clr));
        end
      end

      // transmit clock idle count in line-rate ticks, held clear while off
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tck_idle_q <= 7'h00;
        end else if (tck_ed || off) begin
          tck_idle_q <= 7'h00;
        end else if (xtick && !tcklos[c]) begin
          tck_idle_q <= tck_idle_q + 7'h01;
        end
      end
      assign tcklos[c] = (tck_idle_q > 7'(`TLDC_TCLK_LOSS));

      // settle window after power-down is released
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          toff_prev_q <= 1'b0;
          settle_q    <= 17'h00000;
        end else begin
          toff_prev_q <= off;
          if (off) begin
            settle_q <= 17'h00000;
          end else if (toff_prev_q) begin
            settle_q <= 17'(SETTLE_CYC);
          end else if (settle_q != 17'h00000) begin
            settle_q <= settle_q - 17'h00001;
          end
        end
      end
      assign settle[c] = (settle_q != 17'h00000) | toff_prev_q;

      // high-z causes; enable drops in the same cycle as any cause
      wire hiz_glob = !oe_s | mclk_loss | glob_rst;
      wire hiz_ch   = !txcfg_q[c][`TLDC_B_OE]
                    | off | settle[c]
                    | channel_soft_reset_q[c]
                    | (tcklos[c] & tx_nrz_format[c] & ~tx_loop_or_pattern[c])
                    | (oc_s[c] & txcfg_q[c][`TLDC_B_HIZOC]);
      wire drive    = ~(hiz_glob | hiz_ch);
      assign line_out_tip_oe[c]  = drive;
      assign line_out_ring_oe[c] = drive & ~txcfg_q[c][`TLDC_B_SING];
      assign current_limit[c]    = oc_s[c] & ~txcfg_q[c][`TLDC_B_HIZOC];
      assign tx_termination[3*c +: 3] = txcfg_q[c][2:0];
      assign irq_vec[c] = oc_ist_q[c] & ~oc_msk_q[c];

      // multifunction output and gated system data
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mf_q  <= 1'b0;
          dat_q <= 1'b0;
        end else begin
          mf_q  <= oc_s[c];
          dat_q <= tdat_s[c] & ~off;
        end
      end
      assign tx_multifunction_out[c] = mf_q;
      assign tx_multifunction_oe[c]  = ~off;
      assign tx_core_data[c]         = dat_q;
    end
  endgenerate

  // interrupt output, low while any unmasked sticky bit is set
  assign irq_n = ~|irq_vec;

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  logic [31:0] rd_ch, rd_gl;
  always_comb begin
    case (reg_idx)
      `TLDC_OFF_TXCFG0:  rd_ch = {25'h0, txcfg_q[ch_sel]};
      `TLDC_OFF_STATUS_ZERO:   rd_ch = {27'h0, oc_s[ch_sel], tcklos[ch_sel], 2'b00, settle[ch_sel]};
      `TLDC_OFF_IRQST0:  rd_ch = {27'h0, oc_ist_q[ch_sel], 4'h0};
      `TLDC_OFF_IRQES:   rd_ch = {27'h0, oc_es_q[ch_sel], 4'h0};
      `TLDC_OFF_IRQMSK0: rd_ch = {27'h0, oc_msk_q[ch_sel], 4'h0};
      `TLDC_OFF_CHCFG:   rd_ch = {30'h0, channel_soft_reset_q[ch_sel], 1'b0};
      default:           rd_ch = 32'h0;
    endcase
    case (reg_idx)
      `TLDC_OFF_GCFG:    rd_gl = {31'h0, e1_mode_q};
      `TLDC_OFF_ROMSEL:  rd_gl = {19'h0, samp_idx_q, 4'h0, tpl_sel_q};
      `TLDC_OFF_ROMDAT:  rd_gl = {25'h0, rom_val};
      default:           rd_gl = 32'h0;
    endcase
  end
  assign prdata = (acc && !pwrite) ? (ch_map ? rd_ch : (gl_map ? rd_gl : 32'h0)) : 32'h0;
endmodule : tldc_top

// [design/tldc_defines.svh]
// constants for the transmit line driver control block
`ifndef TLDC_DEFINES_SVH
`define TLDC_DEFINES_SVH
// ----------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------
`define TLDC_NCH          16
`define TLDC_NTPL         8
`define TLDC_NSAMP        20
`define TLDC_ROM_DEPTH    160
// ----------------------------------------------------------------------
// register word offsets (byte address bits 5:2), per channel block and global block
// ----------------------------------------------------------------------
`define TLDC_OFF_TXCFG0   4'h0
`define TLDC_OFF_STATUS_ZERO    4'h1
`define TLDC_OFF_IRQST0   4'h2
`define TLDC_OFF_IRQES    4'h3
`define TLDC_OFF_IRQMSK0  4'h4
`define TLDC_OFF_CHCFG    4'h5
`define TLDC_GLOBAL_BIT   10
`define TLDC_OFF_GCFG     4'h0
`define TLDC_OFF_SWRST    4'h1
`define TLDC_OFF_ROMSEL   4'h2
`define TLDC_OFF_ROMDAT   4'h3
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TLDC_B_OE         6
`define TLDC_B_TOFF       5
`define TLDC_B_HIZOC      4
`define TLDC_B_SING       3
`define TLDC_B_OC         4
`define TLDC_B_TCKLOS     3
`define TLDC_B_SETTLE     0
`define TLDC_B_CHANNEL_SOFT_RESET      1
`define TLDC_B_E1         0
`define TLDC_ROMSEL_SAMP  8
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define TLDC_RST_TXCFG0   7'h00
`define TLDC_RST_IRQMSK   1'b1
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TLDC_CLK_NS       10
`define TLDC_MCLK_LOSS_NS 1000000
`define TLDC_SETTLE_NS    1000000
`define TLDC_HWRST_NS     2000
`define TLDC_HWRST_CYC    ((`TLDC_HWRST_NS + `TLDC_CLK_NS - 1) / `TLDC_CLK_NS)
`define TLDC_MCLK_LOSS_CYC (`TLDC_MCLK_LOSS_NS / `TLDC_CLK_NS)
`define TLDC_SETTLE_CYC   (`TLDC_SETTLE_NS / `TLDC_CLK_NS)
`define TLDC_TCLK_LOSS    64
`define TLDC_PCLK_KHZ     100000
`define TLDC_T1_KHZ       1544
`define TLDC_E1_KHZ       2048
`define TLDC_ACC_W        24
`define TLDC_INC(khz)     (64'(khz) * (64'd1 << `TLDC_ACC_W) / 64'(`TLDC_PCLK_KHZ))
`endif

// [design/tldc_pkg.sv]
// shared types for the transmit line driver control block
package tldc_pkg;
  typedef logic [6:0] tldc_sample_t;
  typedef logic [2:0] tldc_term_t;
  typedef logic [3:0] tldc_chan_t;
endpackage : tldc_pkg

// [test/tldc_top_asserts.sv]
// port-level checks for the transmit line driver control block
`include "tldc_defines.svh"
module tldc_top_asserts #(
  parameter int MCLK_LOSS_CYC = 200
) (
  input wire logic                 pclk,                // clock
  input wire logic                 presetn,             // reset, low
  input wire logic                 psel,                // apb select
  input wire logic                 penable,             // apb access
  input wire logic                 pwrite,              // apb direction
  input wire logic [31:0]          prdata,              // read data
  input wire logic                 pready,              // ready
  input wire logic                 pslverr,             // error
  input wire logic                 oe_pin,              // global enable
  input wire logic                 mclk_pin,            // master clock pin
  input wire logic                 rst_pin_n,           // reset pin
  input wire logic [`TLDC_NCH-1:0] line_out_tip_oe,     // tip enable
  input wire logic [`TLDC_NCH-1:0] line_out_ring_oe,    // ring enable
  input wire logic [`TLDC_NCH-1:0] tx_multifunction_oe, // mf enable
  input wire logic                 line_rate_clock,     // line tick
  input wire logic                 irq_n                // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned mc_q;
  int unsigned rc_q;
  logic        mp_q;
  // stall counters; sync delay is covered by a small margin below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_q <= 0;
      rc_q <= 0;
      mp_q <= 1'b0;
    end else begin
      mp_q <= mclk_pin;
      mc_q <= (mclk_pin != mp_q) ? 0 : mc_q + 1;
      rc_q <= rst_pin_n ? 0 : rc_q + 1;
    end
  end
  AST_OE_PIN: assert property (!oe_pin [*4] |-> line_out_tip_oe == '0) else $error("driven, pin low");
  AST_PAIR: assert property ((line_out_ring_oe & ~line_out_tip_oe) == '0) else $error("ring alone");
  AST_PDN: assert property ((line_out_tip_oe & ~tx_multifunction_oe) == '0) else $error("driven, off");
  AST_MCLK: assert property (mc_q > MCLK_LOSS_CYC + 4 |-> line_out_tip_oe == '0) else $error("clock lost");
  AST_HWRST: assert property (rc_q > `TLDC_HWRST_CYC + 4 |-> line_out_tip_oe == '0) else $error("in reset");
  AST_TICK: assert property (line_rate_clock |=> !line_rate_clock [*8]) else $error("tick gap");
  AST_READY: assert property (psel && penable |-> pready) else $error("wait state");
  AST_ERR: assert property (pslverr |-> psel && penable) else $error("stray error");
  AST_RDZ: assert property (!(psel && penable && !pwrite) |-> prdata == '0) else $error("stray data");
  C_IRQ: cover property ($fell(irq_n));
  C_ERR: cover property (pslverr);
  C_HIZ: cover property ($fell(line_out_tip_oe[0]));
endmodule : tldc_top_asserts
bind tldc_top tldc_top_asserts #(.MCLK_LOSS_CYC(MCLK_LOSS_CYC)) u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .oe_pin(oe_pin), .mclk_pin(mclk_pin), .rst_pin_n(rst_pin_n), .line_out_tip_oe(line_out_tip_oe),
  .line_out_ring_oe(line_out_ring_oe), .tx_multifunction_oe(tx_multifunction_oe),
  .line_rate_clock(line_rate_clock), .irq_n(irq_n));

// [test/tldc_line_model.sv]
// line side model: a short on the pair shows as driver over-current
module tldc_line_model (
  input  wire logic        pclk,       // clock
  input  wire logic [15:0] short_cmd,  // bench orders a short
  output logic      [15:0] overcurrent // sensed over-current
);
  timeunit 1ns;
  timeprecision 1ps;
  // sensed at the transformer, so it lasts as long as the short
  initial overcurrent = '0;
  always @(posedge pclk) overcurrent <= short_cmd;
endmodule : tldc_line_model

// [test/test_tldc_top.sv]
// self-checking bench for the transmit line driver control block
`include "tldc_defines.svh"
module test_tldc_top;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("unexpected %0t %h %h", $time, a, b); end end
  localparam int ML = 200;
  localparam int SC = 50;
  typedef struct {logic [31:0] d; logic t; logic r;} tldc_row_t;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, oe_pin = 0, mclk_pin = 0;
  logic        rst_pin_n = 1, mrun = 1, pready, pslverr, lrc, irq_n, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [15:0] tclk = '0, tdat = '0, nrz = '0, lop = '0, shrt = '0, tstop = '0;
  logic [15:0] oc, tip, ring, clim, mfo, mfoe, cdat;
  logic [47:0] term;
  int          miscompares = 0, checks_done = 0, n, lo;
  tldc_row_t   rows [5] = '{'{32'h40, 1, 1}, '{32'h4b, 1, 0}, '{32'h42, 1, 1}, '{32'h50, 1, 1}, '{32'h00, 0, 0}};
  logic [15:0] rom [8] = '{16'h2097, 16'h254a, 16'h2980, 16'h7127, 16'h309b, 16'h12bc, 16'h020c, 16'h655f};
  initial forever #5 pclk = ~pclk;
  // free-running pins; a stopped transmit clock models a lost source
  always @(posedge pclk) begin
    mclk_pin <= mclk_pin ^ mrun;
    tclk <= tclk ^ ~tstop;
    tdat <= ~tdat;
  end
  tldc_top #(.MCLK_LOSS_CYC(ML), .SETTLE_CYC(SC)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .oe_pin(oe_pin), .mclk_pin(mclk_pin), .rst_pin_n(rst_pin_n), .tx_sys_clock(tclk),
    .tx_sys_data(tdat), .tx_overcurrent(oc), .tx_nrz_format(nrz), .tx_loop_or_pattern(lop),
    .line_out_tip_oe(tip), .line_out_ring_oe(ring), .current_limit(clim), .tx_termination(term),
    .tx_multifunction_out(mfo), .tx_multifunction_oe(mfoe), .tx_core_data(cdat),
    .line_rate_clock(lrc), .irq_n(irq_n));
  tldc_line_model u_line (.pclk(pclk), .short_cmd(shrt), .overcurrent(oc));
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    {rd, err} = {prdata, pslverr};
    if (i >= 50) begin miscompares++; test_done(); end
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  initial begin
    cyc(10);
    {presetn, oe_pin} <= 2'b11;
    `CHK(tip, 16'h0)
    foreach (rows[k]) begin
      apb(1, 12'h000, rows[k].d);
      cyc(2);
      `CHK(tip, {15'h0, rows[k].t})
      `CHK(ring, {15'h0, rows[k].r})
      `CHK(term[2:0], rows[k].d[2:0])
    end
    foreach (rom[k]) begin
      apb(1, 12'h408, {19'h0, rom[k][11:7], 4'h0, rom[k][15:12]});
      apb(0, 12'h40c, 32'h0);
      `CHK(rd[6:0], rom[k][6:0])
    end
    apb(0, 12'h800, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1, 12'h000, 32'h60);
    cyc(2);
    `CHK({tip[0], mfoe[0], cdat[0]}, 3'h0)
    `CHK(cdat[1], ~tdat[1])
    apb(1, 12'h000, 32'h40);
    cyc(SC - 5);
    `CHK(tip[0], 1'b0)
    cyc(10);
    `CHK(tip[0], 1'b1)
    apb(1, 12'h014, 32'h2);
    cyc(2);
    `CHK(tip[0], 1'b0)
    apb(1, 12'h014, 32'h0);
    apb(1, 12'h010, 32'h0);
    shrt[0] <= 1'b1;
    cyc(6);
    `CHK({clim[0], tip[0], irq_n, mfo[0]}, 4'hd)
    apb(1, 12'h000, 32'h50);
    cyc(2);
    `CHK(tip[0], 1'b0)
    shrt[0] <= 1'b0;
    cyc(6);
    apb(0, 12'h004, 32'h0);
    `CHK(rd[4], 1'b0)
    apb(0, 12'h008, 32'h0);
    `CHK(rd[4], 1'b1)
    apb(1, 12'h008, 32'h10);
    cyc(2);
    `CHK(irq_n, 1'b1)
    apb(1, 12'h00c, 32'h10);
    shrt[0] <= 1'b1;
    cyc(6);
    apb(1, 12'h008, 32'h10);
    shrt[0] <= 1'b0;
    cyc(6);
    `CHK(irq_n, 1'b0)
    apb(1, 12'h010, 32'h10);
    cyc(2);
    `CHK(irq_n, 1'b1)
    apb(1, 12'h000, 32'h40);
    {nrz[0], tstop[0]} <= 2'b11;
    cyc(4500);
    `CHK(tip[0], 1'b0)
    lop[0] <= 1'b1;
    cyc(4);
    `CHK(tip[0], 1'b1)
    {lop[0], tstop[0]} <= 2'b00;
    oe_pin <= 1'b0;
    cyc(4);
    `CHK(tip[0], 1'b0)
    apb(0, 12'h000, 32'h0);
    `CHK(rd, 32'h40)
    oe_pin <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      apb(1, 12'h400, m);
      lo = (m ? `TLDC_E1_KHZ : `TLDC_T1_KHZ) * 2000 / `TLDC_PCLK_KHZ;
      n = 0;
      repeat (2000) begin @(posedge pclk); n += lrc; end
      `CHK(n inside {[lo:lo + 1]}, 1'b1)
    end
    apb(1, 12'h404, 32'h0);
    cyc(2);
    `CHK(tip[0], 1'b0)
    apb(0, 12'h010, 32'h0);
    `CHK(rd, 32'h10)
    apb(1, 12'h000, 32'h40);
    rst_pin_n <= 1'b0;
    cyc(`TLDC_HWRST_CYC + 6);
    `CHK(tip[0], 1'b0)
    rst_pin_n <= 1'b1;
    cyc(4);
    apb(1, 12'h000, 32'h40);
    cyc(2);
    `CHK(tip[0], 1'b1)
    mrun <= 1'b0;
    cyc(ML + 8);
    `CHK(tip[0], 1'b0)
    test_done();
  end
endmodule : test_tldc_top
